// ### core/ctm_params.svh
// Purpose: Offsets, fields, reset values and timing for trigger control
// Assumes: clk_i at 125 MHz also serves as the pixel clock
// Notes: Control word bit n of the MSB-first layout sits at Verilog bit 31-n
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH
`define CTM_TC_OFS 12'h830
`define CTM_FRAME_OFS 12'h840
`define CTM_SHUT_OFS 12'h844
`define CTM_DEB_OFS 12'h848
`define CTM_SWTRIG_OFS 12'h84c
`define CTM_STATUS_OFS 12'h850
`define CTM_PRES_BIT 31
`define CTM_ON_BIT 25
`define CTM_POL_BIT 24
`define CTM_SRC_HI 23
`define CTM_SRC_LO 21
`define CTM_VAL_BIT 20
`define CTM_MODE_HI 19
`define CTM_MODE_LO 16
`define CTM_PARM_HI 11
`define CTM_PARM_LO 0
`define CTM_DEB_EN_BIT 16
`define CTM_TC_WMASK 32'h03ef0fff
`define CTM_TC_RESET 32'h00000001
`define CTM_FRAME_RESET 24'h0f4240
`define CTM_SHUT_RESET 24'h000400
`define CTM_DEB_RESET 17'h00000
`define CTM_CLK_NS 8
`define CTM_PIXCLK_NS 8
`define CTM_DEB_MIN_TICKS 16
`define CTM_DEB_MIN_CYC ((`CTM_DEB_MIN_TICKS*`CTM_PIXCLK_NS+`CTM_CLK_NS-1)/`CTM_CLK_NS)
`endif

// ### core/ctm_pkg.sv
// Purpose: Types for camera trigger control
// Assumes: Used with ctm_params.svh
// Notes: State codes are Gray along idle, expose, readout
package ctm_pkg;
	typedef enum logic [1:0] {
		CTM_IDLE = 2'h0,
		CTM_EXPOSE = 2'h1,
		CTM_READOUT = 2'h3
	} ctm_state_t;
	typedef enum logic [3:0] {
		CTM_MODE_EDGE = 4'h0,
		CTM_MODE_SKIP = 4'h3
	} ctm_mode_t;
endpackage

// ### core/ctm_trigger.sv
// Purpose: Trigger mode control with Wishbone register access
// Assumes: Synchronous active-high reset, gpio_i asynchronous
// Notes: Modes other than 0 and 3 with on set produce no exposures
`timescale 1ns/1ns
`include "ctm_params.svh"
module ctm_trigger (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] gpio_i,
	output logic expose_o,
	output logic exposure_start_o,
	output logic image_xmit_o,
	output ctm_pkg::ctm_state_t state_o
);
	import ctm_pkg::*;

	function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0] tc_q, tc_d, rdat_q, rdat_d;
	logic [23:0] frame_q, frame_d, shut_q, shut_d;
	logic [16:0] deb_q, deb_d;
	logic ack_q, ack_d, sw_q, sw_d;
	logic [7:0] lvl_s;
	logic filt_q, filt_d, filt_p_q;
	logic [15:0] deb_cnt_q, deb_cnt_d, thr;
	logic [23:0] fcnt_q, fcnt_d, flen, slen;
	logic [11:0] skip_q, skip_d, nlen;
	ctm_state_t st_q, st_d;
	logic [23:0] cnt_q, cnt_d;
	logic start_q, start_d, xmit_q, xmit_d;
	logic [15:0] img_q, img_d;
	logic wb_req, on, tick, hw_edge, fire, mode0on, mode3on, mode3nx;
	logic [31:0] tc_rd;

	// Control word fields
	assign on = tc_q[`CTM_ON_BIT];
	assign mode0on = on && (tc_q[`CTM_MODE_HI:`CTM_MODE_LO] == CTM_MODE_EDGE);
	assign mode3on = on && (tc_q[`CTM_MODE_HI:`CTM_MODE_LO] == CTM_MODE_SKIP);
	assign mode3nx = tc_d[`CTM_ON_BIT] && (tc_d[`CTM_MODE_HI:`CTM_MODE_LO] == CTM_MODE_SKIP);
	assign tc_rd = tc_q | (32'h1 << `CTM_PRES_BIT)
		| ({31'h0, lvl_s[tc_q[`CTM_SRC_HI:`CTM_SRC_LO]]} << `CTM_VAL_BIT);

	// Wishbone slave, one wait state
	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	always_comb begin
		logic [31:0] m;
		m = 32'h0;
		tc_d = tc_q;
		frame_d = frame_q;
		shut_d = shut_q;
		deb_d = deb_q;
		sw_d = 1'b0;
		ack_d = wb_req;
		rdat_d = rdat_q;
		if (wb_req) begin
			rdat_d = 32'h0;
			case ({wb_adr_i[11:2], 2'h0})
				`CTM_TC_OFS: begin
					rdat_d = tc_rd;
					m = bmerge(tc_q, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						tc_d = m & `CTM_TC_WMASK;
					end
				end
				`CTM_FRAME_OFS: begin
					rdat_d = {8'h0, frame_q};
					m = bmerge({8'h0, frame_q}, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						frame_d = m[23:0];
					end
				end
				`CTM_SHUT_OFS: begin
					rdat_d = {8'h0, shut_q};
					m = bmerge({8'h0, shut_q}, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						shut_d = m[23:0];
					end
				end
				`CTM_DEB_OFS: begin
					rdat_d = {15'h0, deb_q};
					m = bmerge({15'h0, deb_q}, wb_dat_i, wb_sel_i);
					if (wb_we_i) begin
						deb_d = m[16:0];
					end
				end
				`CTM_SWTRIG_OFS: begin
					sw_d = wb_we_i & wb_sel_i[0] & wb_dat_i[0];
				end
				`CTM_STATUS_OFS: begin
					rdat_d = {img_q, 13'h0, filt_q, st_q};
				end
				default: begin
					rdat_d = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tc_q <= `CTM_TC_RESET;
			frame_q <= `CTM_FRAME_RESET;
			shut_q <= `CTM_SHUT_RESET;
			deb_q <= `CTM_DEB_RESET;
			sw_q <= 1'b0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			tc_q <= tc_d;
			frame_q <= frame_d;
			shut_q <= shut_d;
			deb_q <= deb_d;
			sw_q <= sw_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// Two-flop synchronisers on the input pins
	for (genvar g = 0; g < 8; g++) begin : g_sync
		logic a_q, b_q;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				a_q <= 1'b0;
				b_q <= 1'b0;
			end else begin
				a_q <= gpio_i[g];
				b_q <= a_q;
			end
		end
		assign lvl_s[g] = b_q;
	end

	// Debounce of the selected pin
	assign thr = (deb_q[`CTM_DEB_EN_BIT] && deb_q[15:0] > 16'(`CTM_DEB_MIN_CYC)) ?
		deb_q[15:0] : 16'(`CTM_DEB_MIN_CYC);

	always_comb begin
		filt_d = filt_q;
		deb_cnt_d = 16'h0;
		if (lvl_s[tc_q[`CTM_SRC_HI:`CTM_SRC_LO]] != filt_q) begin
			if (deb_cnt_q + 16'h1 >= thr) begin
				filt_d = ~filt_q;
			end else begin
				deb_cnt_d = deb_cnt_q + 16'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filt_q <= 1'b0;
			filt_p_q <= 1'b0;
			deb_cnt_q <= 16'h0;
		end else begin
			filt_q <= filt_d;
			filt_p_q <= filt_q;
			deb_cnt_q <= deb_cnt_d;
		end
	end

	assign hw_edge = (filt_q != filt_p_q) && (filt_q == tc_q[`CTM_POL_BIT]);

	// Frame-period divider and one-of-N counter
	assign flen = (frame_q == 24'h0) ? 24'h1 : frame_q;
	assign slen = (shut_q == 24'h0) ? 24'h1 : shut_q;
	assign nlen = (tc_q[`CTM_PARM_HI:`CTM_PARM_LO] == 12'h0) ? 12'h1 :
		tc_q[`CTM_PARM_HI:`CTM_PARM_LO];
	assign tick = fcnt_q >= flen - 24'h1;

	always_comb begin
		fcnt_d = tick ? 24'h0 : fcnt_q + 24'h1;
		skip_d = skip_q;
		if (!mode3on || !mode3nx) begin
			skip_d = 12'h0;
		end else if (tick) begin
			skip_d = (skip_q >= nlen - 12'h1) ? 12'h0 : skip_q + 12'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fcnt_q <= 24'h0;
			skip_q <= 12'h0;
		end else begin
			fcnt_q <= fcnt_d;
			skip_q <= skip_d;
		end
	end

	// Trigger selection
	always_comb begin
		if (!on) begin
			fire = tick;
		end else if (mode0on) begin
			fire = hw_edge | sw_q;
		end else if (mode3on) begin
			fire = tick && (skip_q == 12'h0);
		end else begin
			fire = 1'b0;
		end
	end

	// Exposure sequencer
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		start_d = 1'b0;
		xmit_d = 1'b0;
		img_d = img_q;
		case (st_q)
			CTM_IDLE: begin
				if (fire) begin
					st_d = CTM_EXPOSE;
					cnt_d = slen;
					start_d = 1'b1;
				end
			end
			CTM_EXPOSE: begin
				if (cnt_q <= 24'h1) begin
					st_d = CTM_READOUT;
					cnt_d = mode0on ? flen : 24'h1;
				end else begin
					cnt_d = cnt_q - 24'h1;
				end
			end
			CTM_READOUT: begin
				if (cnt_q <= 24'h1) begin
					st_d = CTM_IDLE;
					xmit_d = 1'b1;
					img_d = img_q + 16'h1;
				end else begin
					cnt_d = cnt_q - 24'h1;
				end
			end
			default: begin
				st_d = CTM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= CTM_IDLE;
			cnt_q <= 24'h0;
			start_q <= 1'b0;
			xmit_q <= 1'b0;
			img_q <= 16'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			start_q <= start_d;
			xmit_q <= xmit_d;
			img_q <= img_d;
		end
	end

	assign expose_o = (st_q == CTM_EXPOSE);
	assign exposure_start_o = start_q;
	assign image_xmit_o = xmit_q;
	assign state_o = st_q;

	// Checking helpers
	logic [23:0] h_run_q, h_shut_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			h_run_q <= 24'h0;
			h_shut_q <= 24'h1;
		end else begin
			h_run_q <= expose_o ? h_run_q + 24'h1 : 24'h0;
			if (st_q == CTM_IDLE && fire) begin
				h_shut_q <= slen;
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_start_exp;
		start_q && expose_o;
	endsequence
	sequence s_idle_tick;
		st_q == CTM_IDLE && tick;
	endsequence

	a_edge_start: assert property (
		st_q == CTM_IDLE && mode0on && hw_edge |=> s_start_exp)
		else $error("edge trigger did not start exposure");
	a_sw_start: assert property (
		st_q == CTM_IDLE && mode0on && sw_q |=> s_start_exp)
		else $error("software trigger did not start exposure");
	a_exp_len: assert property (
		$fell(expose_o) |-> $past(h_run_q) == h_shut_q - 24'h1)
		else $error("exposure length differs from shutter");
	a_param_free: assert property (
		mode0on |-> skip_q == 12'h0)
		else $error("parameter counter active in mode 0");
	a_rate_limit: assert property (
		mode0on && $fell(expose_o) && flen > 24'h1 |-> st_q == CTM_READOUT ##1 !start_q)
		else $error("mode 0 retriggered without readout gap");
	a_skip_fire: assert property (
		((mode3on && skip_q == 12'h0) and s_idle_tick) |=> s_start_exp)
		else $error("internal trigger missing");
	a_skip_hold: assert property (
		mode3on && st_q == CTM_IDLE && !(tick && skip_q == 12'h0) |=> !start_q)
		else $error("image started outside one of N");
	a_deb_reject: assert property (
		$changed(filt_q) |-> $past(deb_cnt_q) + 16'h1 >= $past(thr))
		else $error("short input pulse accepted");
	a_free_run: assert property (
		((!on) and s_idle_tick) |=> s_start_exp)
		else $error("free-running frame not started");
	a_wb_ack: assert property (
		wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not one cycle after request");
endmodule

// ### tb/ctm_trig_src.sv
// Purpose: Far-side trigger source driving the camera input pins
// Assumes: Pins idle high through pull-ups, active pulses go low
// Notes: Pulse length counted in clk_i cycles
`timescale 1ns/1ns
module ctm_trig_src (
	input wire logic clk_i,
	output logic [7:0] gpio_o
);
	initial begin
		gpio_o = 8'hff;
	end
	// Low pulse on one pin, released back to pull-up level
	task pulse(input int pin, input int len);
		@(posedge clk_i);
		gpio_o[pin] <= 1'b0;
		repeat (len) @(posedge clk_i);
		gpio_o[pin] <= 1'b1;
	endtask
endmodule

// ### tb/camera_trigger_mode_control_tb.sv
// Purpose: Self-checking bench for the trigger mode control
// Assumes: Frame period 20 and shutter 3 written before timing checks
// Notes: Register cases run from a table, trigger cases by hand
`timescale 1ns/1ns
`include "ctm_params.svh"
module camera_trigger_mode_control_tb;
	import ctm_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ctm_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rd;
	logic [31:0] rdat;
	logic ack;
	logic [7:0] gpio;
	logic expo_w;
	logic start_w;
	logic xmit_w;
	ctm_state_t st;
	int miscompares = 0;
	int tests_run = 0;
	int w;
	int xcnt = 0;
	int x1;
	time t1;
	time t2;
	ctm_row_t rows[5] = '{'{`CTM_FRAME_OFS, 32'h14, 32'h14}, '{`CTM_SHUT_OFS, 32'h3, 32'h3},
		'{`CTM_DEB_OFS, 32'h0, 32'h0}, '{12'h900, 32'hffffffff, 32'h0},
		'{`CTM_SWTRIG_OFS, 32'h0, 32'h0}};
	ctm_trigger DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd),
		.wb_ack_o(ack), .gpio_i(gpio), .expose_o(expo_w), .exposure_start_o(start_w),
		.image_xmit_o(xmit_w), .state_o(st));
	ctm_trig_src src (.clk_i(clk_i), .gpio_o(gpio));
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (xmit_w === 1'b1) begin
			xcnt <= xcnt + 1;
		end
	end
	task test_done;
		$display("compares=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
			miscompares++;
		end
	endtask
	task wbx(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = rd;
		if (n >= 50) begin
			miscompares++;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// Start time (0 if none within lim) and exposure width in cycles
	task expo(input int lim, output time ts, output int width);
		int n;
		n = 0;
		width = 0;
		ts = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (start_w !== 1'b1 && n < lim);
		if (start_w === 1'b1) begin
			ts = $time;
			while (expo_w === 1'b1 && width < 99) begin
				width++;
				@(posedge clk_i);
			end
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({26'h0, ack, expo_w, start_w, xmit_w, st}, 32'h0);
		chk(rd, 32'h0);
		wbx(1'b0, `CTM_TC_OFS, 32'h0);
		chk(rdat, 32'h80000001);
		$display("test reset done");
		foreach (rows[i]) begin
			wbx(1'b1, rows[i].a, rows[i].d);
			wbx(1'b0, rows[i].a, 32'h0);
			chk(rdat, rows[i].e);
		end
		wbx(1'b0, `CTM_TC_OFS, 32'h0);
		chk(rdat, 32'h80100001);
		$display("test registers done");
		expo(40, t1, w);
		chk(w, 3);
		expo(40, t2, w);
		chk(32'((t2 - t1) / 8), 32'd20);
		$display("test free run done");
		wbx(1'b1, `CTM_TC_OFS, 32'h02030003);
		expo(200, t1, w);
		x1 = xcnt;
		expo(200, t2, w);
		chk(32'((t2 - t1) / 8), 32'd60);
		chk(32'(xcnt - x1), 32'd1);
		chk(w, 3);
		$display("test one of n done");
		wbx(1'b1, `CTM_TC_OFS, 32'h02000005);
		fork
			wbx(1'b1, `CTM_SWTRIG_OFS, 32'h1);
			expo(10, t1, w);
		join
		chk(32'(t1 != 0), 32'd1);
		chk(w, 3);
		wbx(1'b1, `CTM_SWTRIG_OFS, 32'h1);
		expo(60, t2, w);
		chk(32'(t2), 32'd0);
		$display("test software trigger done");
		wbx(1'b1, `CTM_TC_OFS, 32'h02400000);
		fork
			src.pulse(2, 8);
			expo(60, t1, w);
		join
		chk(32'(t1), 32'd0);
		fork
			src.pulse(2, 30);
			expo(80, t1, w);
		join
		chk(32'(t1 != 0), 32'd1);
		chk(w, 3);
		$display("test pin trigger done");
		test_done;
	end
endmodule
